// ==== include/mwd_pkg.sv ====
// Purpose: Constants for the memory window and chip select decode block
// Assumes: AHB-Lite register access, 32-bit data, one register per word
// Notes:   Register byte address is four times the register index
package mwd_pkg;
  // ==========================================================
  // Register indices
  localparam logic [7:0] port_pin_address_assign_idx = 8'h2d;
  localparam logic [7:0] window_size_register_idx    = 8'h56;
  localparam logic [7:0] window_base_select_idx      = 8'h57;
  localparam logic [7:0] window_one_bank_select_idx  = 8'h58;
  localparam logic [7:0] window_two_bank_select_idx  = 8'h59;
  localparam logic [7:0] select_stretch_register_idx = 8'h5a;
  localparam logic [7:0] select_control_register_idx = 8'h5b;
  localparam logic [7:0] mode_status_idx             = 8'h60;
  // ==========================================================
  // Field positions
  localparam int w2_base_lsb   = 5;
  localparam int w1_base_lsb   = 1;
  localparam int w2_size_lsb   = 4;
  localparam int w1_size_lsb   = 0;
  localparam int bank_lsb      = 1;
  localparam int ctl_io_en     = 7;
  localparam int ctl_io_pol    = 6;
  localparam int ctl_io_av     = 5;
  localparam int ctl_io_sz     = 4;
  localparam int ctl_gprio     = 3;
  localparam int ctl_prog_en   = 2;
  localparam int ctl_prog_sz   = 0;
  localparam int str_prog_lsb  = 2;
  localparam int str_io_lsb    = 0;
  // ==========================================================
  // Write masks (unimplemented bits read zero)
  localparam logic [7:0] pin_assign_mask = 8'h3f;
  localparam logic [7:0] bank_mask       = 8'h7e;
  localparam logic [7:0] base_mask       = 8'hee;
  localparam logic [7:0] size_mask       = 8'h33;
  // ==========================================================
  // Reset values
  localparam logic [7:0] zero_reset      = 8'h00;
  localparam logic [7:0] ctl_reset_off   = 8'h00;
  localparam logic [7:0] ctl_reset_on    = 8'h04;
  localparam logic [7:0] str_reset_norm  = 8'h04;
  localparam logic [7:0] str_reset_test  = 8'h00;
  // Strap capture edge count after reset release, once both flops hold pins
  localparam logic [1:0] strap_capture_count = 2'h2;
  // ==========================================================
  // Window size codes and fixed ranges
  localparam logic [1:0] size_off = 2'h0;
  localparam logic [1:0] size_8k  = 2'h1;
  localparam logic [1:0] size_16k = 2'h2;
  localparam logic [1:0] size_32k = 2'h3;
  localparam logic [15:0] io_base_4k = 16'h1000;
  localparam logic [15:0] io_base_8k = 16'h0000;
  localparam logic [15:0] io_top     = 16'h1fff;
  localparam logic [15:0] reset_vector = 16'hfffe;
  // E clock: two system clocks high, two low
  localparam logic [1:0] e_half_count = 2'h1;
  typedef enum logic [1:0] {mwd_e_low, mwd_e_high, mwd_e_stretch} mwd_e_t;
endpackage

// ==== logic/mwd_decode.sv ====
// Purpose: Memory window bank decode and chip select generation
// Assumes: CPU address/strobe synchronous to hclk; straps synchronised
// Notes:   All outputs but hreadyout and hresp registered, so pins lag the CPU address by one clock
`timescale 1ns/1ps
module mwd_decode
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // CPU bus
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_access,
  input  wire logic        onchip_hit,
  // Mode straps from pins
  input  wire logic        expanded_mode_pin,
  input  wire logic        test_mode_pin,
  input  wire logic        vector_internal_pin,
  // Expansion side
  output logic             e_clock,
  output logic [5:0]       expansion_address_lines,
  output logic [5:0]       expansion_address_enable,
  output logic             program_select_out,
  output logic             io_select_out,
  output logic             bus_stretch
);
  // ========================================================
  // State
  typedef struct packed {
    logic [7:0]  pin_assign;
    logic [7:0]  size_reg;
    logic [7:0]  base_reg;
    logic [7:0]  bank1;
    logic [7:0]  bank2;
    logic [7:0]  stretch_reg;
    logic [7:0]  ctl_reg;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr_idx;
    logic [31:0] rdata;
    logic [2:0]  sync_exp;
    logic [2:0]  sync_exp2;
    logic [1:0]  strap_wait;
    mwd_pkg::mwd_e_t e_state;
    logic [1:0]  e_cnt;
    logic [1:0]  str_left;
    logic        e_out;
    logic [5:0]  xa;
    logic [5:0]  xa_en;
    logic        prog_cs;
    logic        io_cs;
    logic        stretch_out;
  } mwd_state_t;

  mwd_state_t st;
  mwd_state_t next_st;

  // ========================================================
  // Window decode
  logic [1:0]  w1_size;
  logic [1:0]  w2_size;
  logic [2:0]  w1_base;
  logic [2:0]  w2_base;
  logic        w1_hit;
  logic        w2_hit;
  logic        win1;
  logic        win2;
  logic [5:0]  bank_sel;
  logic [1:0]  sel_size;
  logic        base_4000_32k;
  logic        io_range;
  logic        prog_range;
  logic        io_win;
  logic        prog_win;
  logic [5:0]  xa_next;

  // Base normalised: 16K windows on a 16K boundary, 32K windows at 0x0000, 0x4000 or 0x8000
  function automatic logic [2:0] norm_base(input logic [2:0] b,
                                            input logic [1:0] sz);
    logic [2:0] r;
    r = b;
    if (sz == mwd_pkg::size_16k)
      r[0] = 1'b0;
    if (sz == mwd_pkg::size_32k)
    begin
      r[0] = 1'b0;
      if (b[2])
        r = 3'h4;
    end
    return r;
  endfunction

  // Hit when the top CPU bits land in the window extent
  function automatic logic in_window(input logic [15:0] a,
                                     input logic [2:0] b,
                                     input logic [1:0] sz);
    logic h;
    h = 1'b0;
    unique case (sz)
      mwd_pkg::size_off: h = 1'b0;
      mwd_pkg::size_8k:  h = (a[15:13] == b);
      mwd_pkg::size_16k: h = (a[15:14] == b[2:1]);
      mwd_pkg::size_32k: h = (a[15:13] >= b) && (a[15:13] <= b + 3'h3);
    endcase
    return h;
  endfunction

  always_comb
  begin
    w1_size = st.size_reg[mwd_pkg::w1_size_lsb +: 2];
    w2_size = st.size_reg[mwd_pkg::w2_size_lsb +: 2];
    w1_base = norm_base(st.base_reg[mwd_pkg::w1_base_lsb +: 3], w1_size);
    w2_base = norm_base(st.base_reg[mwd_pkg::w2_base_lsb +: 3], w2_size);
    w1_hit  = in_window(cpu_addr, w1_base, w1_size);
    w2_hit  = in_window(cpu_addr, w2_base, w2_size);
    // On-chip memory first, then window one over window two
    win1 = w1_hit && !onchip_hit;
    win2 = w2_hit && !w1_hit && !onchip_hit;
    bank_sel = win1 ? st.bank1[mwd_pkg::bank_lsb +: 6]
                    : st.bank2[mwd_pkg::bank_lsb +: 6];
    sel_size = win1 ? w1_size : w2_size;
    base_4000_32k = (sel_size == mwd_pkg::size_32k) &&
                    ((win1 ? w1_base : w2_base) == 3'h2);
    xa_next = {bank_sel[5:3], cpu_addr[15:13]};
    if (win1 || win2)
    begin
      xa_next = bank_sel;
      // Bits inside the bank size follow the CPU address; a 32K window at 0x4000 inverts line 14
      if (sel_size == mwd_pkg::size_16k)
        xa_next[0] = cpu_addr[13];
      if (sel_size == mwd_pkg::size_32k)
      begin
        xa_next[1:0] = cpu_addr[14:13];
        if (base_4000_32k)
          xa_next[1] = ~cpu_addr[14];
      end
    end
    else
      xa_next[2:0] = cpu_addr[15:13];
    // Chip select ranges
    io_range = st.ctl_reg[mwd_pkg::ctl_io_sz]
             ? (cpu_addr <= mwd_pkg::io_top)
             : (cpu_addr >= mwd_pkg::io_base_4k &&
                cpu_addr <= mwd_pkg::io_top);
    unique case (st.ctl_reg[mwd_pkg::ctl_prog_sz +: 2])
      2'h0: prog_range = 1'b1;
      2'h1: prog_range = cpu_addr[15];
      2'h2: prog_range = (cpu_addr[15:14] == 2'h3);
      2'h3: prog_range = (cpu_addr[15:13] == 3'h7);
    endcase
    // Registers, RAM, ROM, EEPROM rank above all selects
    io_win = cpu_access && !onchip_hit && io_range && st.sync_exp2[0] &&
             st.ctl_reg[mwd_pkg::ctl_io_en];
    // General selects sit outside this block; with the priority bit set
    // they would outrank program, which here only loses to I/O
    prog_win = cpu_access && !onchip_hit && !io_win && prog_range &&
               st.sync_exp2[0] &&
               st.ctl_reg[mwd_pkg::ctl_prog_en];
  end

  // ========================================================
  // Next state
  always_comb
  begin
    logic       wr_now;
    logic [7:0] wb;
    logic       sel_any;
    wr_now  = 1'b0;
    wb      = 8'h00;
    sel_any = 1'b0;
    next_st = st;
    // Straps: two flops, then one capture after reset release
    next_st.sync_exp  = {vector_internal_pin, test_mode_pin,
                         expanded_mode_pin};
    next_st.sync_exp2 = st.sync_exp;
    // Only the second flop is read, so a metastable first flop never leaks
    if (st.strap_wait != 2'h3)
      next_st.strap_wait = st.strap_wait + 2'h1;
    if (st.strap_wait == mwd_pkg::strap_capture_count)
    begin
      // Test mode gets an enabled program select with no stretch
      if (st.sync_exp2[1])
      begin
        next_st.ctl_reg     = mwd_pkg::ctl_reset_on;
        next_st.stretch_reg = mwd_pkg::str_reset_test;
      end
      else
      begin
        // Every normal mode gets one stretch cycle on program select, none on I/O select
        next_st.stretch_reg = mwd_pkg::str_reset_norm;
        if (st.sync_exp2[0] && !st.sync_exp2[2])
          next_st.ctl_reg   = mwd_pkg::ctl_reset_on;
      end
    end
    // AHB-Lite data phase: writes land here, reads were prepared earlier
    wr_now = st.wr_pend;
    wb     = hwdata[7:0];
    if (wr_now)
    begin
      unique case (st.addr_idx)
        mwd_pkg::port_pin_address_assign_idx:
          next_st.pin_assign = wb & mwd_pkg::pin_assign_mask;
        mwd_pkg::window_size_register_idx:
          next_st.size_reg = wb & mwd_pkg::size_mask;
        mwd_pkg::window_base_select_idx:
          next_st.base_reg = wb & mwd_pkg::base_mask;
        mwd_pkg::window_one_bank_select_idx:
          next_st.bank1 = wb & mwd_pkg::bank_mask;
        mwd_pkg::window_two_bank_select_idx:
          next_st.bank2 = wb & mwd_pkg::bank_mask;
        mwd_pkg::select_stretch_register_idx:
          next_st.stretch_reg = wb;
        mwd_pkg::select_control_register_idx:
          next_st.ctl_reg = wb;
        default: next_st.ctl_reg = st.ctl_reg;
      endcase
    end
    next_st.wr_pend = 1'b0;
    next_st.rd_pend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      next_st.addr_idx = haddr[9:2];
      next_st.wr_pend  = hwrite;
      next_st.rd_pend  = !hwrite;
      unique case (haddr[9:2])
        mwd_pkg::port_pin_address_assign_idx:
          next_st.rdata = {24'h0, st.pin_assign};
        mwd_pkg::window_size_register_idx:
          next_st.rdata = {24'h0, st.size_reg};
        mwd_pkg::window_base_select_idx:
          next_st.rdata = {24'h0, st.base_reg};
        mwd_pkg::window_one_bank_select_idx:
          next_st.rdata = {24'h0, st.bank1};
        mwd_pkg::window_two_bank_select_idx:
          next_st.rdata = {24'h0, st.bank2};
        mwd_pkg::select_stretch_register_idx:
          next_st.rdata = {24'h0, st.stretch_reg};
        mwd_pkg::select_control_register_idx:
          next_st.rdata = {24'h0, st.ctl_reg};
        mwd_pkg::mode_status_idx:
          next_st.rdata = {24'h0, 1'b0, st.io_cs, st.prog_cs, win2, win1,
                           st.sync_exp2};
        default: next_st.rdata = 32'h0;
      endcase
    end
    // ======================================================
    // E clock with stretch on chip-selected cycles
    sel_any = prog_win || io_win;
    unique case (st.e_state)
      mwd_pkg::mwd_e_low:
        if (st.e_cnt == mwd_pkg::e_half_count)
        begin
          next_st.e_state = mwd_pkg::mwd_e_high;
          next_st.e_cnt   = 2'h0;
          next_st.e_out   = 1'b1;
          // Stretch count latched at E rise, counted down once per stretch cycle
          next_st.str_left = !sel_any ? 2'h0
            : (prog_win ? {1'b0, st.stretch_reg[mwd_pkg::str_prog_lsb]}
                        : st.stretch_reg[mwd_pkg::str_io_lsb +: 2]);
        end
        else
          next_st.e_cnt = st.e_cnt + 2'h1;
      mwd_pkg::mwd_e_high:
        if (st.e_cnt == mwd_pkg::e_half_count)
        begin
          next_st.e_cnt = 2'h0;
          if (st.str_left != 2'h0)
            next_st.e_state = mwd_pkg::mwd_e_stretch;
          else
          begin
            next_st.e_state = mwd_pkg::mwd_e_low;
            next_st.e_out   = 1'b0;
          end
        end
        else
          next_st.e_cnt = st.e_cnt + 2'h1;
      mwd_pkg::mwd_e_stretch:
        if (st.e_cnt == 2'h3)
        begin
          next_st.e_cnt    = 2'h0;
          next_st.str_left = st.str_left - 2'h1;
          if (st.str_left == 2'h1)
          begin
            next_st.e_state = mwd_pkg::mwd_e_low;
            next_st.e_out   = 1'b0;
          end
        end
        else
          next_st.e_cnt = st.e_cnt + 2'h1;
      default:
        next_st.e_state = mwd_pkg::mwd_e_low;
    endcase
    next_st.stretch_out = (st.e_state == mwd_pkg::mwd_e_stretch);
    // ======================================================
    // Pins
    next_st.xa    = xa_next & st.pin_assign[5:0];
    next_st.xa_en = ~st.pin_assign[5:0] | ~{6{st.sync_exp2[0]}};
    next_st.prog_cs = !prog_win;
    // I/O select: address-valid timing or gated by E high
    next_st.io_cs = (io_win && (st.ctl_reg[mwd_pkg::ctl_io_av] ||
                    st.e_out)) ~^ st.ctl_reg[mwd_pkg::ctl_io_pol];
  end

  // ========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '{pin_assign: mwd_pkg::zero_reset,
              size_reg: mwd_pkg::zero_reset,
              base_reg: mwd_pkg::zero_reset,
              bank1: mwd_pkg::zero_reset,
              bank2: mwd_pkg::zero_reset,
              stretch_reg: mwd_pkg::zero_reset,
              ctl_reg: mwd_pkg::ctl_reset_off,
              e_state: mwd_pkg::mwd_e_low,
              prog_cs: 1'b1,
              io_cs: 1'b1,
              xa_en: 6'h3f,
              default: '0};
    end
    else
      st <= next_st;
  end

  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign e_clock   = st.e_out;
  assign expansion_address_lines  = st.xa;
  assign expansion_address_enable = st.xa_en;
  assign program_select_out       = st.prog_cs;
  assign io_select_out            = st.io_cs;
  assign bus_stretch              = st.stretch_out;
endmodule

// ==== test/memory_window_chip_select_decode_test.sv ====
// Purpose: Self-checking bench for the window decode block
// Assumes: Zero-wait register bus; decode one clock behind CPU address
// Notes:   Banks and addresses random from a fixed seed
`timescale 1ns/1ps
module memory_window_chip_select_decode_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        cpu_access, onchip_hit, exp_pin, test_pin, clr, pol;
  logic        e_clock, prog, io, stretch, sx, vec;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] cpu_addr, a;
  logic [5:0]  xa, xa_en, xs, es;
  logic [7:0]  b1, b2, mdl [256];
  logic [7:0]  ids [8] = '{8'h2d, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a,
                           8'h5b, 8'h10};
  int          err_count, n_compared, seed, dp, di, p0, i0, k;
  int          prog_count, io_count, max_period;

  mwd_decode u_dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .cpu_addr, .cpu_access, .onchip_hit, .expanded_mode_pin(exp_pin),
    .test_mode_pin(test_pin), .vector_internal_pin(vec), .e_clock,
    .expansion_address_lines(xa), .expansion_address_enable(xa_en),
    .program_select_out(prog), .io_select_out(io), .bus_stretch(stretch)
  );
  mwd_ext_dev u_dev
  (
    .hclk, .hresetn, .e_clock, .program_select_out(prog),
    .io_select_out(io), .io_active_high(pol), .clear_max(clr),
    .prog_count, .io_count, .max_period
  );

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask

  function automatic logic [7:0] mask(input logic [7:0] i);
    case (i)
      8'h2d:        mask = mwd_pkg::pin_assign_mask;
      8'h56:        mask = mwd_pkg::size_mask;
      8'h57:        mask = mwd_pkg::base_mask;
      8'h58, 8'h59: mask = mwd_pkg::bank_mask;
      8'h5a, 8'h5b: mask = 8'hff;
      default:      mask = 8'h00;
    endcase
  endfunction

  task automatic bus(input logic w, input logic [7:0] i, d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rdy();
    rd = hrdata;
    if (w)
      mdl[i] = d & mask(i);
  endtask

  task automatic rchk(input logic [7:0] i);
    bus(1'b0, i, 8'h00);
    chk("register", {24'h0, mdl[i]}, rd);
  endtask

  task automatic acc(input logic [15:0] ad, input logic hit);
    p0 = prog_count;
    i0 = io_count;
    @(posedge hclk);
    clr        <= 1'b1;
    cpu_addr   <= ad;
    cpu_access <= 1'b1;
    onchip_hit <= hit;
    repeat (3) @(posedge hclk);
    clr <= 1'b0;
    #1;
    xs = xa;
    es = xa_en;
    sx = 1'b0;
    repeat (24)
    begin
      @(negedge hclk);
      sx |= stretch;
      @(posedge hclk);
    end
    cpu_access <= 1'b0;
    onchip_hit <= 1'b0;
    repeat (6) @(posedge hclk);
    dp = prog_count - p0;
    di = io_count - i0;
  endtask

  task automatic rst(input logic e, t, v);
    hresetn  <= 1'b0;
    exp_pin  <= e;
    test_pin <= t;
    vec      <= v;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    foreach (mdl[i])
      mdl[i] = 8'h00;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {hsel, hwrite, cpu_access, onchip_hit, clr, pol, hresetn} = 7'h0;
    {htrans, haddr, hwdata, cpu_addr} = '0;
    {err_count, n_compared} = '0;
    seed = 32'h07f4;
    rst(1'b1, 1'b0, 1'b0);
    mdl[8'h5a] = 8'h04;
    mdl[8'h5b] = 8'h04;
    foreach (ids[j])
      rchk(ids[j]);
    foreach (ids[j])
    begin
      bus(1'b1, ids[j], 8'hf7);
      rchk(ids[j]);
    end
    $display("Register test done");
    bus(1'b1, 8'h56, 8'h00);
    bus(1'b1, 8'h2d, 8'h3f);
    a = 16'($random(seed));
    acc(a, 1'b0);
    chk("low lines", {29'h0, a[15:13]}, {29'h0, xs[2:0]});
    chk("pin enables", 32'h0, {26'h0, es});
    bus(1'b1, 8'h2d, 8'h00);
    acc(a, 1'b0);
    chk("gpio pins", 32'h3f, {26'h0, es});
    bus(1'b1, 8'h2d, 8'h3f);
    for (k = 0; k < 8; k++)
    begin
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      a  = {k[2:0], 13'($random(seed))};
      bus(1'b1, 8'h56, 8'h11);
      bus(1'b1, 8'h57, {k[2:0], 1'b0, k[2:0], 1'b0});
      bus(1'b1, 8'h58, b1);
      bus(1'b1, 8'h59, b2);
      acc(a, 1'b0);
      chk("window one", {26'h0, b1[6:1]}, {26'h0, xs});
      bus(1'b1, 8'h56, 8'h10);
      acc(a, 1'b0);
      chk("window two", {26'h0, b2[6:1]}, {26'h0, xs});
    end
    $display("8K window test done");
    bus(1'b1, 8'h56, 8'h03);
    for (k = 0; k < 8; k++)
    begin
      b1 = 8'($random(seed));
      a  = (k[2] ? 16'h8000 : {1'b0, k[1], 14'h0})
           + {1'b0, 15'($random(seed))};
      bus(1'b1, 8'h57, {4'h0, k[2:0], 1'b0});
      bus(1'b1, 8'h58, b1);
      acc(a, 1'b0);
      chk("32K bank", {28'h0, b1[6:3]}, {28'h0, xs[5:2]});
      if (k[2:1] == 2'b01)
        chk("line 14", {31'h0, ~a[14]}, {31'h0, xs[1]});
    end
    bus(1'b1, 8'h57, 8'h04);
    acc(16'hc123, 1'b0);
    chk("line 14 idle", 32'h1, {31'h0, xs[1]});
    $display("32K window test done");
    bus(1'b1, 8'h56, 8'h00);
    bus(1'b1, 8'h5b, 8'h04);
    bus(1'b1, 8'h5a, 8'h04);
    acc(16'he000, 1'b0);
    chk("program select", 32'h1, 32'(dp != 0));
    chk("program stretch", 32'd8, max_period);
    chk("program stretch flag", 32'h1, {31'h0, sx});
    acc(16'he000, 1'b1);
    chk("on-chip access", 32'h0, dp);
    pol = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h5a, {6'h0, k[1:0]});
      bus(1'b1, 8'h5b, 8'hc4);
      acc(16'h1800, 1'b0);
      chk("io select 4K", 32'h1, 32'(di != 0));
      chk("io over program", 32'h0, dp);
      chk("io stretch", 4 + 4 * k, max_period);
      chk("stretch seen", 32'(k != 0), {31'h0, sx});
      acc(16'h0800, 1'b0);
      chk("io 4K miss", 32'h0, di);
      bus(1'b1, 8'h5b, 8'hd4);
      acc(16'h0800, 1'b0);
      chk("io select 8K", 32'h1, 32'(di != 0));
    end
    $display("Select test done");
    rst(1'b0, 1'b0, 1'b0);
    mdl[8'h5a] = 8'h04;
    rchk(8'h5b);
    rchk(8'h5a);
    acc(16'he000, 1'b0);
    chk("single chip", 32'h0, dp);
    rst(1'b1, 1'b0, 1'b1);
    mdl[8'h5a] = 8'h04;
    rchk(8'h5b);
    rchk(8'h5a);
    rst(1'b1, 1'b1, 1'b0);
    mdl[8'h5b] = 8'h04;
    rchk(8'h5b);
    rchk(8'h5a);
    acc(16'he000, 1'b0);
    chk("test mode select", 32'h1, 32'(dp != 0));
    chk("test mode stretch", 32'd4, max_period);
    $display("Reset mode test done");
    summarize();
  end
endmodule

// ==== test/mwd_decode_properties.sv ====
// Purpose: Port checks for the window decode block
// Assumes: One clock; outputs registered after inputs
// Notes:   Shadows pin assignment from the register bus
`timescale 1ns/1ps
module mwd_decode_properties
(
  // Clock, reset and register bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // CPU side and straps
  input wire logic        cpu_access,
  input wire logic        onchip_hit,
  input wire logic        expanded_mode_pin,
  input wire logic        test_mode_pin,
  // Expansion side
  input wire logic        e_clock,
  input wire logic [5:0]  expansion_address_enable,
  input wire logic        program_select_out
);
  // ==========================================================
  // Shadow of pin assignment; two cycles of slack for the update
  logic       wr_pend;
  logic [5:0] pin_sh;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      pin_sh  <= 6'h00;
    end
    else
    begin
      if (wr_pend)
        pin_sh <= hwdata[5:0];
      wr_pend <= hsel && hready && htrans[1] && hwrite
                 && haddr[9:2] == 8'h2d;
    end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_no_wait_a:
    assert property (hreadyout && !hresp)
    else $error("Register bus stalled or errored");
  read_upper_zero_a:
    assert property (hrdata[31:8] == 24'h0)
    else $error("Read data above low byte");
  onchip_no_select_a:
    assert property (cpu_access && onchip_hit |=> program_select_out)
    else $error("Program select on on-chip access");
  select_cause_a:
    assert property ($fell(program_select_out) |->
      $past(cpu_access) && !$past(onchip_hit))
    else $error("Program select without external access");
  e_high_two_a:
    assert property ($rose(e_clock) |-> e_clock [*2])
    else $error("E high phase too short");
  e_low_two_a:
    assert property ($fell(e_clock) |-> !e_clock ##1 !e_clock)
    else $error("E low phase too short");
  pin_gpio_a:
    assert property ((~pin_sh & ~$past(pin_sh) & ~$past(pin_sh, 2)
      & ~expansion_address_enable) == 6'h00)
    else $error("Unassigned pin driven as address");
  single_chip_a:
    assert property (!expanded_mode_pin && !test_mode_pin |->
      program_select_out)
    else $error("Program select outside expanded mode");
  cover property ($fell(program_select_out));
  cover property (wr_pend);
  cover property ($rose(e_clock) ##1 e_clock [*4]);
endmodule

bind mwd_decode mwd_decode_properties u_props
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .cpu_access, .onchip_hit,
  .expanded_mode_pin, .test_mode_pin, .e_clock,
  .expansion_address_enable, .program_select_out
);

// ==== test/mwd_ext_dev.sv ====
// Purpose: External memory and peripheral on the expansion bus
// Assumes: Selects and E sampled on the system clock
// Notes:   Counts enables and measures the longest E period
`timescale 1ns/1ps
module mwd_ext_dev
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Expansion bus
  input  wire logic e_clock,
  input  wire logic program_select_out,
  input  wire logic io_select_out,
  input  wire logic io_active_high,
  input  wire logic clear_max,
  // Observations
  output int        prog_count,
  output int        io_count,
  output int        max_period
);
  logic last_e;
  logic last_p;
  logic last_io;
  int   cnt;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      last_e     <= 1'b0;
      last_p     <= 1'b1;
      last_io    <= 1'b1;
      cnt        <= 0;
      prog_count <= 0;
      io_count   <= 0;
      max_period <= 0;
    end
    else
    begin
      last_e  <= e_clock;
      last_p  <= program_select_out;
      last_io <= io_select_out;
      cnt     <= (e_clock && !last_e) ? 1 : cnt + 1;
      // Program memory only wakes on a low level
      if (last_p && !program_select_out)
        prog_count <= prog_count + 1;
      // Peripheral enable level follows the set polarity
      if ((io_select_out ^ last_io) && io_select_out == io_active_high)
        io_count <= io_count + 1;
      // Longest E period shows how far a cycle was stretched
      if (clear_max)
        max_period <= 0;
      else if (e_clock && !last_e && cnt > max_period)
        max_period <= cnt;
    end
endmodule
